// *** hw/cmcs_load_timer.sv ***
`timescale 1ns/1ps
module cmcs_load_timer
    import cmcs_pkg::*;
#(
    parameter int CYCLES = LOAD_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_clr,
    input wire logic i_start,
    output logic o_busy,
    output logic o_done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD_LAST = CW'(CYCLES);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    logic [CW-1:0] cnt_ff;
    logic done_ff;

    // restart on a new write: last request wins, one transfer reported
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= '0;
        end else if (i_ce) begin
            if (i_clr) begin
                cnt_ff <= CNT_ZERO;
            end else if (i_start) begin
                cnt_ff <= LOAD_LAST;
            end else if (cnt_ff != CNT_ZERO) begin
                cnt_ff <= cnt_ff - CNT_ONE;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            done_ff <= 1'b0;
        end else if (i_ce) begin
            done_ff <= !i_clr && !i_start && (cnt_ff == CNT_ONE);
        end
    end

    assign o_busy = (cnt_ff != CNT_ZERO);
    assign o_done = done_ff;
endmodule

// *** hw/cmcs_pkg.sv ***
package cmcs_pkg;
    // ----------------------------------------
    // register offsets (byte address = index * 4)
    // ----------------------------------------
    localparam logic [3:0] IDX_LOOP_CFG = 4'h5;
    localparam logic [3:0] IDX_RST_IRQ1 = 4'h6;
    localparam logic [3:0] IDX_IRQ2 = 4'h7;
    localparam logic [3:0] IDX_LRDI_CTL = 4'h8;
    localparam logic [3:0] IDX_EVT_STAT = 4'hC;
    localparam logic [3:0] IDX_EVT_MASK = 4'hD;
    localparam int ADDR_W = 6;
    localparam int IDX_LSB = 2;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int B_LINE_LB = 7;
    localparam int B_SER_DIAG = 6;
    localparam int B_LOOP_TIMING_SELECT = 5;
    localparam int B_PATH_LB = 4;
    localparam int B_AUTO_LRDI = 3;
    localparam int B_AUTO_PRDI = 2;
    localparam int B_AUTO_LFEBE = 1;
    localparam int B_AUTO_PFEBE = 0;
    localparam int B_SOFT_RST = 7;
    localparam int IRQ1_W = 7;
    localparam int LRDI_LSB = 1;
    localparam int LRDI_W = 7;
    localparam int EVT_W = 2;
    localparam int EV_LOAD_DONE = 0;
    localparam int EV_LRDI_RISE = 1;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_LOOP_CFG = 8'h0F;
    localparam logic [7:0] RST_LRDI_CTL = 8'h32;
    localparam logic [6:0] LRDI_EN_MASK = 7'h7F;
    localparam logic [1:0] RST_EVT_MASK = 2'h0;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int LOAD_NS = 200;
    localparam int CLK_NS = 40;
    localparam int LOAD_CYC = (LOAD_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } cmcs_bus_type;
endpackage

// *** hw/cmcs_top.sv ***
`timescale 1ns/1ps
module cmcs_top
    import cmcs_pkg::*;
#(
    parameter int LOAD_CYCLES = LOAD_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [IRQ1_W-1:0] i_irq1_src,
    input wire logic [7:0] i_irq2_src,
    input wire logic [LRDI_W-1:0] i_line_alarm,
    input wire logic i_path_alarm_any,
    input wire logic i_tx_path_oh,
    input wire logic i_rx_path_oh,
    input wire logic i_tx_serial,
    input wire logic i_rx_serial,
    input wire logic i_synth_reference_clock_en,
    input wire logic i_recovered_clock_en,
    output logic o_rx_path_oh_sel,
    output logic o_rx_serial_sel,
    output logic o_tx_serial_sel,
    output logic o_tx_clock_en,
    output logic o_loop_timing_select,
    output logic o_auto_line_rdi_req,
    output logic o_auto_path_rdi_req,
    output logic o_auto_line_febe_en,
    output logic o_auto_path_febe_en,
    output logic o_channel_rst,
    output logic o_standby,
    output logic o_pm_load,
    output logic o_channel_transfer_in_progress,
    output logic o_irq
);
    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    cmcs_bus_type bus_ff;
    logic [31:0] rdata_ff;
    logic [3:0] idx;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] nxt_rdata;

    logic [7:0] loop_cfg_ff;
    logic soft_rst_ff;
    logic [LRDI_W-1:0] lrdi_en_ff;
    logic [EVT_W-1:0] evt_stat_ff;
    logic [EVT_W-1:0] evt_mask_ff;
    logic [EVT_W-1:0] evt_set;
    logic line_rdi_ff;
    logic line_rdi_prev_ff;
    logic load_busy;
    logic load_done;
    logic load_start;

    assign idx = i_avs_address[ADDR_W-1:IDX_LSB];
    // one wait state, then accept in ACK cycle; a frozen clock enable keeps the master waiting
    assign wr_hit = i_ce && i_avs_write && (bus_ff == BUS_ACK);
    // read captured in the wait cycle so readdata is a flop when accepted
    assign rd_hit = i_ce && i_avs_read && (bus_ff == BUS_IDLE);
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && ((bus_ff != BUS_ACK) || !i_ce);

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_ff <= BUS_IDLE;
        end else if (i_ce) begin
            unique case (bus_ff)
                BUS_IDLE: begin
                    if (i_avs_read || i_avs_write) begin
                        bus_ff <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    bus_ff <= BUS_IDLE;
                end
                default: begin
                    bus_ff <= BUS_IDLE;
                end
            endcase
        end
    end

    // unmapped offsets read zero, writes dropped
    always_comb begin
        nxt_rdata = ZERO32;
        unique case (idx)
            IDX_LOOP_CFG: nxt_rdata[7:0] = loop_cfg_ff;
            IDX_RST_IRQ1: nxt_rdata[7:0] = {soft_rst_ff, i_irq1_src};
            IDX_IRQ2: nxt_rdata[7:0] = i_irq2_src;
            IDX_LRDI_CTL: nxt_rdata[7:0] = {lrdi_en_ff, 1'b0};
            IDX_EVT_STAT: nxt_rdata[EVT_W-1:0] = evt_stat_ff;
            IDX_EVT_MASK: nxt_rdata[EVT_W-1:0] = evt_mask_ff;
            default: nxt_rdata = ZERO32;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= ZERO32;
        end else if (rd_hit) begin
            rdata_ff <= nxt_rdata;
        end
    end
    // read data registered: valid at the edge waitrequest is low
    assign o_avs_readdata = rdata_ff;

    // ----------------------------------------
    // soft reset (hardware reset only clears it)
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            soft_rst_ff <= 1'b0;
        end else if (wr_hit && idx == IDX_RST_IRQ1 && i_avs_byteenable[0]) begin
            soft_rst_ff <= i_avs_writedata[B_SOFT_RST];
        end
    end

    // ----------------------------------------
    // channel configuration, reset by either reset
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            loop_cfg_ff <= RST_LOOP_CFG;
        end else if (i_ce) begin
            // soft reset acts as hardware reset
            if (soft_rst_ff) begin
                loop_cfg_ff <= RST_LOOP_CFG;
            end else if (wr_hit && idx == IDX_LOOP_CFG && i_avs_byteenable[0]) begin
                loop_cfg_ff <= i_avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            lrdi_en_ff <= RST_LRDI_CTL[7:LRDI_LSB];
        end else if (i_ce) begin
            if (soft_rst_ff) begin
                lrdi_en_ff <= RST_LRDI_CTL[7:LRDI_LSB];
            end else if (wr_hit && idx == IDX_LRDI_CTL && i_avs_byteenable[0]) begin
                lrdi_en_ff <= i_avs_writedata[7:LRDI_LSB];
            end
        end
    end

    // ----------------------------------------
    // counter load
    // ----------------------------------------
    // any write to summary two starts load
    assign load_start = wr_hit && (idx == IDX_IRQ2);
    assign o_pm_load = load_start;

    cmcs_load_timer #(
        .CYCLES(LOAD_CYCLES)
    ) u_load (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_clr(soft_rst_ff),
        .i_start(load_start),
        .o_busy(load_busy),
        .o_done(load_done)
    );
    assign o_channel_transfer_in_progress = load_busy;

    // ----------------------------------------
    // remote defect requests
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            line_rdi_ff <= 1'b0;
        end else if (i_ce) begin
            line_rdi_ff <= !soft_rst_ff && loop_cfg_ff[B_AUTO_LRDI]
                           && |(i_line_alarm & lrdi_en_ff & LRDI_EN_MASK);
        end
    end
    assign o_auto_line_rdi_req = line_rdi_ff;
    // path request gated by auto enable
    assign o_auto_path_rdi_req = !soft_rst_ff && loop_cfg_ff[B_AUTO_PRDI] && i_path_alarm_any;
    assign o_auto_line_febe_en = loop_cfg_ff[B_AUTO_LFEBE];
    assign o_auto_path_febe_en = loop_cfg_ff[B_AUTO_PFEBE];

    // ----------------------------------------
    // loopback and timing steering
    // ----------------------------------------
    // path loopback, tx keeps running
    assign o_rx_path_oh_sel = loop_cfg_ff[B_PATH_LB] ? i_tx_path_oh : i_rx_path_oh;
    assign o_rx_serial_sel = loop_cfg_ff[B_SER_DIAG] ? i_tx_serial : i_rx_serial;
    // line loopback, rx keeps running; relies on
    assign o_tx_serial_sel = loop_cfg_ff[B_LINE_LB] ? i_rx_serial : i_tx_serial;
    assign o_tx_clock_en = loop_cfg_ff[B_LOOP_TIMING_SELECT] ? i_recovered_clock_en : i_synth_reference_clock_en;
    assign o_loop_timing_select = loop_cfg_ff[B_LOOP_TIMING_SELECT];

    // channel held in reset and standby
    assign o_channel_rst = soft_rst_ff;
    assign o_standby = soft_rst_ff;

    // ----------------------------------------
    // events and interrupt
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            line_rdi_prev_ff <= 1'b0;
        end else if (i_ce) begin
            line_rdi_prev_ff <= line_rdi_ff;
        end
    end

    always_comb begin
        evt_set = '0;
        evt_set[EV_LOAD_DONE] = load_done;
        evt_set[EV_LRDI_RISE] = line_rdi_ff && !line_rdi_prev_ff;
    end

    // set wins over write-one-to-clear
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            evt_stat_ff <= '0;
        end else if (i_ce) begin
            if (wr_hit && idx == IDX_EVT_STAT && i_avs_byteenable[0]) begin
                evt_stat_ff <= (evt_stat_ff & ~i_avs_writedata[EVT_W-1:0]) | evt_set;
            end else begin
                evt_stat_ff <= evt_stat_ff | evt_set;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            evt_mask_ff <= RST_EVT_MASK;
        end else if (wr_hit && idx == IDX_EVT_MASK && i_avs_byteenable[0]) begin
            evt_mask_ff <= i_avs_writedata[EVT_W-1:0];
        end
    end

    // summary flags feed the interrupt, cleared only at source
    assign o_irq = |(evt_stat_ff & evt_mask_ff) || |i_irq1_src || |i_irq2_src;
endmodule

// *** tb/cmcs_chk.sv ***
`timescale 1ns/1ps
module cmcs_chk
    import cmcs_pkg::*;
#(
    parameter int LOAD_CYCLES = LOAD_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [IRQ1_W-1:0] i_irq1_src,
    input wire logic [LRDI_W-1:0] i_line_alarm,
    input wire logic i_path_alarm_any,
    input wire logic i_synth_reference_clock_en,
    input wire logic i_recovered_clock_en,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic o_tx_clock_en,
    input wire logic o_loop_timing_select,
    input wire logic o_auto_line_rdi_req,
    input wire logic o_auto_path_rdi_req,
    input wire logic o_channel_rst,
    input wire logic o_standby,
    input wire logic o_pm_load,
    input wire logic o_channel_transfer_in_progress,
    input wire logic o_irq
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [7:0] tip_cnt_ff;
    logic alarm_any;
    assign alarm_any = |i_line_alarm;
    // counts enabled cycles of one transfer so the length can be judged when it ends
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            tip_cnt_ff <= 8'h00;
        end else if (i_ce) begin
            tip_cnt_ff <= o_channel_transfer_in_progress ? tip_cnt_ff + 8'h01 : 8'h00;
        end
    end
    a_path_rdi_gate: assert property (o_auto_path_rdi_req |-> i_path_alarm_any)
        else $error("path rdi request without alarm");
    a_line_rdi_cause: assert property (o_auto_line_rdi_req |-> $past(alarm_any))
        else $error("line rdi request without alarm");
    a_tx_clock_mux: assert property (o_tx_clock_en == (o_loop_timing_select ? i_recovered_clock_en
        : i_synth_reference_clock_en))
        else $error("tx timing source wrong");
    a_standby_follows: assert property (o_standby == o_channel_rst)
        else $error("standby differs from channel reset");
    a_load_start: assert property (i_avs_write && !o_avs_waitrequest && !o_channel_rst
        && i_avs_address[ADDR_W-1:IDX_LSB] == IDX_IRQ2 |=> o_channel_transfer_in_progress)
        else $error("load did not start");
    a_load_pulse: assert property (o_pm_load |-> ##[0:1] o_channel_transfer_in_progress ##1 !o_pm_load)
        else $error("counter load pulse wrong");
    a_load_length: assert property ($fell(o_channel_transfer_in_progress) && !o_channel_rst
        |-> int'(tip_cnt_ff) == LOAD_CYCLES)
        else $error("transfer flag length wrong");
    a_irq_sources: assert property (|i_irq1_src |-> ##[0:1] o_irq)
        else $error("irq low with active source");
    a_summary_read: assert property (i_avs_read && !o_avs_waitrequest && $stable(i_irq1_src)
        && i_avs_address[ADDR_W-1:IDX_LSB] == IDX_RST_IRQ1
        |-> o_avs_readdata == {24'h00_0000, o_channel_rst, i_irq1_src})
        else $error("summary one read wrong");
endmodule
bind cmcs_top cmcs_chk #(.LOAD_CYCLES(LOAD_CYCLES)) i_cmcs_chk (.*);

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import cmcs_pkg::*;
;
    localparam int LC = 3;
    logic i_sys_clk = 1'h0, i_rst = 1'h1, rd = 1'h0, wr = 1'h0, pa = 1'h0, ce = 1'h1;
    logic [5:0] adr = 6'h00, dv = 6'h00;
    logic [31:0] wdat = 32'h0000_0000, q, rdat;
    logic [6:0] s1 = 7'h00, la = 7'h00;
    logic [7:0] s2 = 8'h00;
    logic wq, rpo, rss, tss, tce, lts, lrq, prq, lfe, pfe, crs, sby, pml, tip, irq;
    int error_cnt = 0, cmp_count = 0, seed = 51737, n, cfg, lc;
    always #20 i_sys_clk = ~i_sys_clk;
    cmcs_top #(.LOAD_CYCLES(LC)) i_cmcs_top (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(ce),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_irq1_src(s1), .i_irq2_src(s2), .i_line_alarm(la),
        .i_path_alarm_any(pa), .i_tx_path_oh(dv[0]), .i_rx_path_oh(dv[1]), .i_tx_serial(dv[2]), .i_rx_serial(dv[3]),
        .i_synth_reference_clock_en(dv[4]), .i_recovered_clock_en(dv[5]), .o_rx_path_oh_sel(rpo),
        .o_rx_serial_sel(rss), .o_tx_serial_sel(tss), .o_tx_clock_en(tce), .o_loop_timing_select(lts),
        .o_auto_line_rdi_req(lrq), .o_auto_path_rdi_req(prq), .o_auto_line_febe_en(lfe), .o_auto_path_febe_en(pfe),
        .o_channel_rst(crs), .o_standby(sby), .o_pm_load(pml), .o_channel_transfer_in_progress(tip), .o_irq(irq));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // waitrequest is combinational, so its settled value before the edge is what the edge samples
    task xfer(input logic w, input logic [3:0] idx, input logic [7:0] d);
        n = 0;
        @(posedge i_sys_clk);
        adr <= {idx, 2'h0};
        wdat <= {24'h00_0000, d};
        rd <= !w;
        wr <= w;
        do begin
            @(negedge i_sys_clk);
            n++;
            q = rdat;
        end while (wq !== 1'h0 && n < 50);
        @(posedge i_sys_clk);
        rd <= 1'h0;
        wr <= 1'h0;
        if (n >= 50) error_cnt++;
    endtask
    task rdc(input logic [3:0] idx, input logic [7:0] exp);
        xfer(1'h0, idx, 8'h00);
        chk(q, {24'h00_0000, exp});
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_rst <= 1'h0;
        rdc(IDX_LOOP_CFG, 8'h0F);
        rdc(IDX_LRDI_CTL, 8'h32);
        rdc(IDX_RST_IRQ1, 8'h00);
        rdc(IDX_EVT_MASK, 8'h00);
        xfer(1'h1, 4'h3, 8'hFF);
        rdc(4'h3, 8'h00);
        $display("test reset values done");
        for (int k = 0; k < 48; k++) begin
            cfg = ((k % 16) << 4) | ($random(seed) & 15);
            // no network sync unit in this bench, so loop timing may be set
            cfg = cfg[7] ? cfg | 32 : cfg;
            cfg = cfg[5] ? cfg & 191 : cfg;
            lc = $random(seed) & 254;
            xfer(1'h1, IDX_LOOP_CFG, cfg[7:0]);
            xfer(1'h1, IDX_LRDI_CTL, lc[7:0]);
            rdc(IDX_LOOP_CFG, cfg[7:0]);
            rdc(IDX_LRDI_CTL, lc[7:0]);
            @(posedge i_sys_clk);
            dv <= 6'($random(seed));
            la <= 7'($random(seed));
            pa <= 1'($random(seed));
            @(posedge i_sys_clk);
            @(negedge i_sys_clk);
            chk(rpo, cfg[4] ? dv[0] : dv[1]);
            chk(rss, cfg[6] ? dv[2] : dv[3]);
            chk(tss, cfg[7] ? dv[3] : dv[2]);
            chk(tce, cfg[5] ? dv[5] : dv[4]);
            chk({lts, lfe, pfe}, {cfg[5], cfg[1:0]});
            chk(prq, cfg[2] & pa);
            chk(lrq, cfg[3] & |(la & lc[7:1]));
        end
        $display("test loopback and rdi done");
        for (int k = 0; k < 8; k++) begin
            s1 <= 7'($random(seed));
            s2 <= 8'($random(seed));
            xfer(1'h1, IDX_RST_IRQ1, 8'h7F);
            rdc(IDX_RST_IRQ1, {1'h0, s1});
            rdc(IDX_IRQ2, s2);
            chk(irq, |{s1, s2});
        end
        $display("test summaries done");
        s1 <= 7'h00;
        s2 <= 8'h00;
        la <= 7'h00;
        xfer(1'h1, IDX_EVT_STAT, 8'h03);
        xfer(1'h1, IDX_EVT_MASK, 8'h01);
        rdc(IDX_EVT_STAT, 8'h00);
        xfer(1'h1, IDX_IRQ2, 8'h5A);
        // clock enable low must freeze the load counter
        ce <= 1'h0;
        repeat (3) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk(tip, 1'h1);
        @(posedge i_sys_clk);
        ce <= 1'h1;
        lc = 0;
        do begin
            @(negedge i_sys_clk);
            lc += (tip === 1'h1);
        end while (tip === 1'h1 && lc < 20);
        chk(lc, LC);
        rdc(IDX_EVT_STAT, 8'h01);
        chk(irq, 1'h1);
        xfer(1'h1, IDX_EVT_MASK, 8'h00);
        @(negedge i_sys_clk);
        chk(irq, 1'h0);
        xfer(1'h1, IDX_EVT_MASK, 8'h01);
        xfer(1'h1, IDX_EVT_STAT, 8'h01);
        @(negedge i_sys_clk);
        chk(irq, 1'h0);
        rdc(IDX_EVT_STAT, 8'h00);
        $display("test load and interrupt done");
        xfer(1'h1, IDX_RST_IRQ1, 8'h80);
        @(negedge i_sys_clk);
        chk({crs, sby}, 2'h3);
        xfer(1'h1, IDX_LOOP_CFG, 8'hA0);
        rdc(IDX_LOOP_CFG, 8'h0F);
        rdc(IDX_RST_IRQ1, 8'h80);
        xfer(1'h1, IDX_RST_IRQ1, 8'h00);
        @(negedge i_sys_clk);
        chk({crs, sby}, 2'h0);
        xfer(1'h1, IDX_RST_IRQ1, 8'h80);
        i_rst <= 1'h1;
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'h0;
        rdc(IDX_RST_IRQ1, 8'h00);
        $display("test soft reset done");
        end_sim();
    end
endmodule
